/* File: include/lcg_pkg.sv */
package lcg_pkg;

  // Register map, byte addresses on the plain register port
  localparam logic [7:0]  LCG_ADDR_DEVICE_IDENTIFICATION = 8'h00;
  localparam logic [7:0]  LCG_ADDR_UNIQUE_ID_LO          = 8'h04;
  localparam logic [7:0]  LCG_ADDR_UNIQUE_ID_HI          = 8'h08;
  localparam logic [7:0]  LCG_ADDR_LIFECYCLE_STATUS      = 8'h0C;
  localparam logic [7:0]  LCG_ADDR_BOOT_CONTROL          = 8'h10;

  // Identification word layout
  localparam int          LCG_REV_MSB                    = 31;
  localparam int          LCG_REV_LSB                    = 28;
  localparam int          LCG_FIXED_MSB                  = 27;
  localparam int          LCG_FIXED_LSB                  = 0;

  // Status register layout
  localparam int          LCG_STAT_STATE_LSB             = 0;
  localparam int          LCG_STAT_ENGINE_BIT            = 4;
  localparam int          LCG_STAT_AUTH_BIT              = 5;
  localparam int          LCG_STAT_BOOT_LSB              = 8;

  // Boot control register bits
  localparam int          LCG_CTRL_PASS_BIT              = 0;
  localparam int          LCG_CTRL_FAIL_BIT              = 1;

  localparam logic [31:0] LCG_RDATA_RESET                = 32'h0000_0000;
  localparam logic [63:0] LCG_UID_RESET                  = 64'h0000_0000_0000_0000;

  typedef enum logic [3:0] {
    LCG_FAB_STATE          = 4'h1,
    LCG_SECURITY_OFF_STATE = 4'h2,
    LCG_PROVISIONING_STATE = 4'h4,
    LCG_SECURED_STATE      = 4'h8
  } lcg_life_type;

  typedef enum logic [3:0] {
    LCG_BOOT_ROM       = 4'h1,
    LCG_BOOT_VERIFY    = 4'h2,
    LCG_BOOT_LOADER    = 4'h4,
    LCG_BOOT_SUSPENDED = 4'h8
  } lcg_boot_type;

endpackage : lcg_pkg

/* File: rtl/lcg_id_rom.sv */
`timescale 1ns/10ps
// Small identity store; read data registered
module lcg_id_rom
  import lcg_pkg::*;
#(
  parameter logic [3:0]  PRODUCT_REVISION = 4'h1,
  parameter logic [27:0] PRODUCT_FIXED    = 28'h000_0ABC  // Arbitrary value
) (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [1:0]  sel_i,
  input  wire logic [63:0] unique_id_i,
  output logic      [31:0] rdata_o
);

  typedef struct packed {
    logic [31:0] rdata;
  } lcg_rom_state_type;

  lcg_rom_state_type st_q;
  lcg_rom_state_type st_d;

  always_comb begin
    st_d = st_q;
    unique case (sel_i)
      2'h0:    st_d.rdata = {PRODUCT_REVISION, PRODUCT_FIXED};
      2'h1:    st_d.rdata = unique_id_i[31:0];
      default: st_d.rdata = unique_id_i[63:32];
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '{rdata: LCG_RDATA_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;

endmodule : lcg_id_rom

/* File: rtl/lcg_lifecycle_gate.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - A read-only 32-bit identification register names the product and revision.
// - Its bits 31..28 hold the revision and bits 27..0 a fixed product value.
// - A 64-bit per-chip identifier from one-time storage is readable.
// - Until the option bits are taken the state reads as the fab state.
// - A bonded bit picks security-off or provisioning and software cannot change it.
// - In the security-off state the security engine stays disabled.
// - Provisioning allows the engine, and the secure-boot fuse moves it to secured.
// - Authenticated boot is enabled towards the boot ROM only in the secured state.
// - Each selector is a single bit with no other encodings.
// - Bonded and fused parameters can never be cleared or rewritten.
// - After reset the boot ROM runs first; only in the secured state does it check the loader before handing over.
// - A failed check suspends boot instead of running the image.
module lcg_lifecycle_gate
  import lcg_pkg::*;
#(
  parameter logic [3:0]  PRODUCT_REVISION = 4'h1,
  parameter logic [27:0] PRODUCT_FIXED    = 28'h000_0ABC  // Arbitrary value
) (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        bond_secure_i,
  input  wire logic        otp_secure_boot_i,
  input  wire logic [63:0] otp_unique_id_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic      [3:0]  life_state_o,
  output logic             engine_enable_o,
  output logic             auth_boot_enable_o,
  output logic             boot_rom_active_o,
  output logic             loader_release_o,
  output logic             boot_suspended_o
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic         captured;
    lcg_life_type life;
    logic         engine_en;
    logic         auth_en;
    lcg_boot_type boot;
    logic         rom_active;
    logic         loader_rel;
    logic         suspended;
    logic         rd_pend;
    logic         rd_rom;
    logic [31:0]  rd_local;
    logic [63:0]  uid;
  } lcg_state_type;

  lcg_state_type st_q;
  lcg_state_type st_d;
  logic [1:0]    rom_sel;
  logic [31:0]   rom_rdata;
  logic          hit_ctrl;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rom_sel = (reg_addr_i == LCG_ADDR_UNIQUE_ID_LO) ? 2'h1 :
              (reg_addr_i == LCG_ADDR_UNIQUE_ID_HI) ? 2'h2 : 2'h0;
    hit_ctrl = reg_wr_i && (reg_addr_i == LCG_ADDR_BOOT_CONTROL);
  end

  always_comb begin
    st_d = st_q;
    // Sampled once at the first edge after release; nothing reopens it
    if (!st_q.captured) begin
      st_d.captured = 1'b1;
      st_d.uid      = otp_unique_id_i;
      // Single-bit selectors: every combination decodes to a legal state
      if (!bond_secure_i) begin
        st_d.life = LCG_SECURITY_OFF_STATE;
      end else if (otp_secure_boot_i) begin
        st_d.life = LCG_SECURED_STATE;
      end else begin
        st_d.life = LCG_PROVISIONING_STATE;
      end
      st_d.engine_en = bond_secure_i;
      st_d.auth_en   = bond_secure_i && otp_secure_boot_i;
      st_d.boot      = (bond_secure_i && otp_secure_boot_i) ? LCG_BOOT_VERIFY
                                                            : LCG_BOOT_LOADER;
    end
    // Boot ROM reports its verdict; only meaningful while verifying
    unique case (st_q.boot)
      LCG_BOOT_VERIFY: begin
        if (hit_ctrl && reg_wdata_i[LCG_CTRL_FAIL_BIT]) begin
          st_d.boot = LCG_BOOT_SUSPENDED;
        end else if (hit_ctrl && reg_wdata_i[LCG_CTRL_PASS_BIT]) begin
          st_d.boot = LCG_BOOT_LOADER;
        end
      end
      LCG_BOOT_ROM, LCG_BOOT_LOADER, LCG_BOOT_SUSPENDED: begin
        // Suspension is terminal until reset
      end
      default: st_d.boot = LCG_BOOT_SUSPENDED;
    endcase
    // Boot decodes kept in flops so the pins never glitch
    st_d.rom_active = (st_d.boot == LCG_BOOT_ROM) || (st_d.boot == LCG_BOOT_VERIFY);
    st_d.loader_rel = (st_d.boot == LCG_BOOT_LOADER);
    st_d.suspended  = (st_d.boot == LCG_BOOT_SUSPENDED);
    // No write path touches life, enables or uid after capture
    st_d.rd_pend  = reg_rd_i;
    st_d.rd_rom   = (reg_addr_i == LCG_ADDR_DEVICE_IDENTIFICATION) ||
                    (reg_addr_i == LCG_ADDR_UNIQUE_ID_LO) ||
                    (reg_addr_i == LCG_ADDR_UNIQUE_ID_HI);
    st_d.rd_local = LCG_RDATA_RESET;
    if (reg_addr_i == LCG_ADDR_LIFECYCLE_STATUS) begin
      st_d.rd_local[LCG_STAT_STATE_LSB +: 4] = st_q.life;
      st_d.rd_local[LCG_STAT_ENGINE_BIT]     = st_q.engine_en;
      st_d.rd_local[LCG_STAT_AUTH_BIT]       = st_q.auth_en;
      st_d.rd_local[LCG_STAT_BOOT_LSB +: 4]  = st_q.boot;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '{captured:  1'b0,
                life:      LCG_FAB_STATE,
                engine_en: 1'b0,
                auth_en:   1'b0,
                boot:       LCG_BOOT_ROM,
                rom_active: 1'b1,
                loader_rel: 1'b0,
                suspended:  1'b0,
                rd_pend:   1'b0,
                rd_rom:    1'b0,
                rd_local:  LCG_RDATA_RESET,
                uid:       LCG_UID_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  lcg_id_rom #(
    .PRODUCT_REVISION (PRODUCT_REVISION),
    .PRODUCT_FIXED    (PRODUCT_FIXED)
  ) u_id_rom (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .sel_i       (rom_sel),
    .unique_id_i (st_q.uid),
    .rdata_o     (rom_rdata)
  );

  // Read data only in the cycle after the strobe; zero otherwise
  assign reg_rdata_o        = !st_q.rd_pend ? LCG_RDATA_RESET :
                              (st_q.rd_rom ? rom_rdata : st_q.rd_local);
  assign life_state_o       = st_q.life;
  assign engine_enable_o    = st_q.engine_en;
  assign auth_boot_enable_o = st_q.auth_en;
  assign boot_rom_active_o  = st_q.rom_active;
  assign loader_release_o   = st_q.loader_rel;
  assign boot_suspended_o   = st_q.suspended;

endmodule : lcg_lifecycle_gate

/* File: test/lcg_chk.sv */
`timescale 1ns/10ps
module lcg_chk
  import lcg_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic [3:0] life_state_o,
  input wire logic       engine_enable_o,
  input wire logic       auth_boot_enable_o,
  input wire logic       boot_rom_active_o,
  input wire logic       loader_release_o,
  input wire logic       boot_suspended_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_auth_only: assert property (
    auth_boot_enable_o == (life_state_o == LCG_SECURED_STATE)) else $error("auth enable");
  chk_off_engine: assert property (
    life_state_o == LCG_SECURITY_OFF_STATE |-> !engine_enable_o) else $error("engine on");
  chk_prov_engine: assert property (
    life_state_o == LCG_PROVISIONING_STATE |-> engine_enable_o) else $error("engine off");
  chk_state_code: assert property ($onehot(life_state_o)) else $error("state code");
  chk_state_held: assert property (
    !$past(sys_rst_i, 2) |-> $stable({life_state_o, auth_boot_enable_o})) else $error("moved");
  chk_susp_hold: assert property (
    boot_suspended_o |=> boot_suspended_o && !loader_release_o) else $error("resumed");
  chk_rom_first: assert property (
    $rose(loader_release_o) |-> !auth_boot_enable_o || $past(boot_rom_active_o)) else $error("rom");
  chk_susp_secured: assert property (
    boot_suspended_o |-> auth_boot_enable_o && !boot_rom_active_o) else $error("suspend");
  cover property (boot_suspended_o);
  cover property (loader_release_o && auth_boot_enable_o);
  cover property (engine_enable_o && !auth_boot_enable_o);
endmodule : lcg_chk
////////////////////////////////////////
bind lcg_lifecycle_gate lcg_chk lcg_chk_inst (.ref_clk_i, .sys_rst_i, .life_state_o,
  .engine_enable_o, .auth_boot_enable_o, .boot_rom_active_o, .loader_release_o, .boot_suspended_o);

/* File: test/lcg_strap_model.sv */
`timescale 1ns/10ps
module lcg_strap_model (
  input  wire logic [1:0]  mode_i,
  output logic             bond_o,
  output logic             fuse_o,
  output logic      [63:0] uid_o
);
  // Image headers as the supplier lays them out; no module here reads them
  localparam logic [31:0] MANIFEST_VERSION = 32'h0000_0001;
  localparam logic [31:0] IMAGE_VERSION    = 32'h0000_0001;
  assign {fuse_o, bond_o, uid_o} = {mode_i, 64'h0123_4567_89AB_CDEF}; // Arbitrary id
endmodule : lcg_strap_model

/* File: test/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import lcg_pkg::*;
  logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1, wr = 1'b0, rd = 1'b0, bond, fuse;
  logic [1:0]  mode_q = 2'h0;
  logic [7:0]  addr = 8'h00;
  logic [8:0]  obs;
  logic [31:0] wdata = 32'h0, rdata;
  logic [63:0] uid;
  int          failures = 0, cmp_count = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  lcg_strap_model lcg_strap_model_inst (.mode_i(mode_q), .bond_o(bond), .fuse_o(fuse), .uid_o(uid));
  lcg_lifecycle_gate lcg_lifecycle_gate_inst (.ref_clk_i, .sys_rst_i, .bond_secure_i(bond),
    .otp_secure_boot_i(fuse), .otp_unique_id_i(uid), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .life_state_o(obs[3:0]),
    .engine_enable_o(obs[8]), .auth_boot_enable_o(obs[7]), .boot_rom_active_o(obs[6]),
    .loader_release_o(obs[5]), .boot_suspended_o(obs[4]));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    failures += int'(got !== exp);
    if (got !== exp) $display("wrong value at %0t: %h not %h", $time, got, exp);
  endtask : cmp
  // Read data checked in its one valid cycle; writes expect idle zero
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    @(posedge ref_clk_i);
    {wr, rd, addr, wdata} <= {w, !w, a, d};
    @(posedge ref_clk_i);
    {wr, rd} <= 2'b00;
    #1 cmp(rdata, e);
  endtask : bus
  // Straps are set while reset is held and taken at the first edge after release
  task automatic boot(input logic [1:0] m, input logic [3:0] st, input logic [4:0] f);
    @(posedge ref_clk_i);
    {mode_q, sys_rst_i} <= {m, 1'b1};
    repeat (5) @(posedge ref_clk_i);
    cmp({23'h0, obs}, {23'h0, 5'b00100, LCG_FAB_STATE});
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 cmp({23'h0, obs}, {23'h0, f, st});
  endtask : boot
  task automatic t_off();
    boot(2'h0, LCG_SECURITY_OFF_STATE, 5'b00010);
    bus(1'b0, LCG_ADDR_DEVICE_IDENTIFICATION, 32'h0, 32'h1000_0ABC);
    bus(1'b0, LCG_ADDR_UNIQUE_ID_LO, 32'h0, 32'h89AB_CDEF);
    bus(1'b0, LCG_ADDR_UNIQUE_ID_HI, 32'h0, 32'h0123_4567);
    bus(1'b0, 8'h14, 32'h0, 32'h0);
    bus(1'b1, LCG_ADDR_LIFECYCLE_STATUS, 32'h0000_0008, 32'h0);
    bus(1'b1, LCG_ADDR_BOOT_CONTROL, 32'h0000_0002, 32'h0);
    bus(1'b0, LCG_ADDR_LIFECYCLE_STATUS, 32'h0, 32'h0000_0402);
  endtask : t_off
  task automatic t_sec(input logic [31:0] verdict, input logic [4:0] f);
    boot(2'h3, LCG_SECURED_STATE, 5'b11100);
    mode_q <= 2'h0;
    bus(1'b1, LCG_ADDR_BOOT_CONTROL, verdict, 32'h0);
    cmp({23'h0, obs}, {23'h0, f, LCG_SECURED_STATE});
    bus(1'b1, LCG_ADDR_BOOT_CONTROL, 32'h1, 32'h0);
    cmp({23'h0, obs}, {23'h0, f, LCG_SECURED_STATE});
  endtask : t_sec
  task automatic final_report();
    $display("failures %0d, comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial begin
    t_off();
    boot(2'h1, LCG_PROVISIONING_STATE, 5'b10010);
    t_sec(32'h2, 5'b11001);
    t_sec(32'h1, 5'b11010);
    t_sec(32'h3, 5'b11001);
    final_report();
  end
  initial #8000 begin
    failures++;
    final_report();
  end
endmodule : testbench
